// *** hdl/dio_pkg.sv ***
// Constants, types and register map of the seven-pin digital I/O port.
// Assumes a 50 MHz APB clock; all pins are sampled on that clock.
package dio_pkg;
  localparam int NUM_PINS = 7;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int CNT_W    = 24;

  typedef enum logic [1:0] {
    MODE_DEFAULT = 2'b00,
    MODE_INPUT   = 2'b01,
    MODE_OUTPUT  = 2'b10,
    MODE_PWM     = 2'b11
  } pin_mode_t;

  // Per-pin setting word, low bits of the configuration register
  typedef struct packed {
    logic      invert;
    logic      value;
    pin_mode_t mode;
  } pin_cfg_t;

  localparam pin_cfg_t             CFG_RESET    = '0;
  localparam logic [CNT_W-1:0]     PWM_RESET    = 24'h0;
  localparam logic [ADDR_W-1:0]    CFG_BASE     = 8'h00;
  localparam logic [ADDR_W-1:0]    PERIOD_BASE  = 8'h20;
  localparam logic [ADDR_W-1:0]    LOW_BASE     = 8'h40;
  localparam logic [ADDR_W-1:0]    CTRL_ADDR    = 8'h60;
  localparam logic [ADDR_W-1:0]    STATUS_ADDR  = 8'h64;
  localparam int                   CTRL_EXT_TRIG_BIT = 0;
  localparam int                   STATUS_PROT_BIT   = 7;
  localparam int                   STATUS_LOAD_BIT   = 8;

  // Default role of each pin, by index
  localparam int PIN_CLEAR    = 0;
  localparam int PIN_PROT     = 1;
  localparam int PIN_ONOFF    = 2;
  localparam int PIN_TRIG     = 3;
  localparam int PIN_INHIBIT  = 4;
  localparam int PIN_SYNC_ON  = 5;
  localparam int PIN_SYNC_OFF = 6;

  localparam int CLK_PERIOD_NS  = 20;
  localparam int PULSE_WIDTH_NS = 30000;
  localparam int PULSE_CYCLES   =
    (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_W        = $clog2(PULSE_CYCLES + 1);
endpackage

// *** hdl/pwm_gen.sv ***
// One PWM generator: a free counter over a programmed period.
// Assumes period and low count are stable registers of the caller.
`timescale 1ns/10ps
module pwm_gen #(
  parameter int CNT_W = 24
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             enable,
  input  wire logic [CNT_W-1:0] period,
  input  wire logic [CNT_W-1:0] low_cycles,
  output logic                  low_phase_q
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             low_phase_d;

  always_comb begin
    cnt_d       = cnt_q;
    low_phase_d = 1'b0;
    if (!enable || period == '0) begin
      cnt_d = '0;
    end else begin
      // Wrap on period change too, so a shorter period never stalls
      cnt_d       = (cnt_q >= period - 1'b1) ? '0 : cnt_q + 1'b1;
      low_phase_d = (cnt_q < low_cycles);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q       <= '0;
      low_phase_q <= 1'b0;
    end else begin
      cnt_q       <= cnt_d;
      low_phase_q <= low_phase_d;
    end
  end
endmodule

// *** hdl/digital_io_port.sv ***
// Seven-pin configurable digital I/O port with an APB register slave.
// Assumes pins and core status inputs are synchronous to pclk.
//
// Behaviour
// [R1] - Seven pins, each default role or generic
// [R2] - Pins 1-4: clear, protection, on/off, trigger
// [R3] - Pins 5-7: inhibit, sync on, sync off
// [R4] - Pulses are high-to-low edges, in and out
// [R5] - Generic output: true drives low, false high
// [R6] - Generic input level readable by control logic
// [R7] - PWM output from per-pin period and duty
// [R8] - Invert option flips a pin's active level
// [R9] - Inhibit active high; load off while active
// [R10] - Clear pulse clears a present protection state
// [R11] - Load off-to-on without protection emits pulse
// [R12] - Pin four triggers when external source chosen
// [R13] - Duty sets the low fraction of each period
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module digital_io_port
  import dio_pkg::*;
#(
  parameter int PWM_W = dio_pkg::CNT_W
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [dio_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [dio_pkg::DATA_W-1:0]  pwdata,
  output logic                             pready,
  output logic [dio_pkg::DATA_W-1:0]       prdata,
  output logic                             pslverr,
  input  wire logic [dio_pkg::NUM_PINS-1:0] pin_in,
  output logic [dio_pkg::NUM_PINS-1:0]     pin_out,
  output logic [dio_pkg::NUM_PINS-1:0]     pin_oe,
  input  wire logic                        prot_active,
  input  wire logic                        load_on,
  output logic                             prot_clear,
  output logic                             trigger,
  output logic                             inhibit,
  output logic                             sync_on,
  output logic                             sync_off
);
  import dio_pkg::*;
  function automatic logic [ADDR_W-1:0] slot(logic [ADDR_W-1:0] base,
                                            int idx);
    return base + ADDR_W'(idx * 4);
  endfunction
  // Register file
  pin_cfg_t          cfg_q    [NUM_PINS];
  pin_cfg_t          cfg_d    [NUM_PINS];
  logic [PWM_W-1:0]  period_q [NUM_PINS];
  logic [PWM_W-1:0]  period_d [NUM_PINS];
  logic [PWM_W-1:0]  low_q    [NUM_PINS];
  logic [PWM_W-1:0]  low_d    [NUM_PINS];
  logic              ext_trig_q;
  logic              ext_trig_d;
  logic              wr_en;
  assign wr_en = psel && penable && pwrite;
  always_comb begin
    cfg_d      = cfg_q;
    period_d   = period_q;
    low_d      = low_q;
    ext_trig_d = ext_trig_q;
    if (wr_en) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (paddr == slot(CFG_BASE, i))
          cfg_d[i] = pin_cfg_t'(pwdata[$bits(pin_cfg_t)-1:0]);
        if (paddr == slot(PERIOD_BASE, i))
          period_d[i] = pwdata[PWM_W-1:0];
        if (paddr == slot(LOW_BASE, i))
          low_d[i] = pwdata[PWM_W-1:0];
      end
      if (paddr == CTRL_ADDR)
        ext_trig_d = pwdata[CTRL_EXT_TRIG_BIT];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q      <= '{default: CFG_RESET};
      period_q   <= '{default: PWM_RESET};
      low_q      <= '{default: PWM_RESET};
      ext_trig_q <= 1'b0;
    end else begin
      cfg_q      <= cfg_d;
      period_q   <= period_d;
      low_q      <= low_d;
      ext_trig_q <= ext_trig_d;
    end
  end
  // Per-pin decode of the external level
  logic [NUM_PINS-1:0] level;
  logic [NUM_PINS-1:0] level_prev_q;
  logic [NUM_PINS-1:0] fall;
  logic [NUM_PINS-1:0] dflt;
  logic [NUM_PINS-1:0] pin_true;
  logic [NUM_PINS-1:0] pwm_low;
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      level[i]    = pin_in[i] ^ cfg_q[i].invert;         // [R8]
      fall[i]     = level_prev_q[i] & ~level[i];         // [R4]
      dflt[i]     = (cfg_q[i].mode == MODE_DEFAULT);
      pin_true[i] = ~level[i];                           // [R6]
    end
  end
  // One generator per pin; cheap compared with sharing a counter
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : gen_pwm
      pwm_gen #(
        .CNT_W (PWM_W)
      ) u_pwm (
        .pclk        (pclk),
        .presetn     (presetn),
        .enable      (cfg_q[g].mode == MODE_PWM),
        .period      (period_q[g]),
        .low_cycles  (low_q[g]),
        .low_phase_q (pwm_low[g])                        // [R7] [R13]
      );
    end
  endgenerate
  // Pin drivers, events and the outgoing clear pulse
  logic [NUM_PINS-1:0] pin_out_d;
  logic [NUM_PINS-1:0] pin_oe_d;
  logic [PULSE_W-1:0]  pulse_cnt_q;
  logic [PULSE_W-1:0]  pulse_cnt_d;
  logic                load_prev_q;
  logic                pulse_on;
  logic                prot_clear_d;
  logic                trigger_d;
  logic                inhibit_d;
  logic                sync_on_d;
  logic                sync_off_d;
  assign pulse_on = (pulse_cnt_q != '0);
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin             // [R1]
      pin_out_d[i] = 1'b1;
      pin_oe_d[i]  = 1'b0;
      unique case (cfg_q[i].mode)
        MODE_DEFAULT: begin
          if (i == PIN_CLEAR && pulse_on) begin
            pin_oe_d[i]  = 1'b1;
            pin_out_d[i] = cfg_q[i].invert;              // [R4] [R11]
          end else if (i == PIN_PROT) begin
            pin_oe_d[i]  = 1'b1;
            pin_out_d[i] = ~prot_active ^ cfg_q[i].invert; // [R2]
          end else if (i == PIN_ONOFF) begin
            pin_oe_d[i]  = 1'b1;
            pin_out_d[i] = load_on ^ cfg_q[i].invert;    // [R2]
          end
        end
        MODE_INPUT:  pin_oe_d[i] = 1'b0;                 // [R6]
        MODE_OUTPUT: begin
          pin_oe_d[i]  = 1'b1;
          pin_out_d[i] = ~cfg_q[i].value ^ cfg_q[i].invert; // [R5] [R8]
        end
        MODE_PWM: begin
          pin_oe_d[i]  = 1'b1;
          pin_out_d[i] = ~pwm_low[i] ^ cfg_q[i].invert;  // [R7] [R13]
        end
      endcase
    end
    // Own clear pulse is ignored as an input while it is driven
    prot_clear_d = dflt[PIN_CLEAR] && !pulse_on && fall[PIN_CLEAR] &&
                   prot_active;                          // [R10]
    trigger_d    = dflt[PIN_TRIG] && fall[PIN_TRIG] && ext_trig_q; // [R12]
    inhibit_d    = dflt[PIN_INHIBIT] && level[PIN_INHIBIT];        // [R9]
    sync_on_d    = dflt[PIN_SYNC_ON] && fall[PIN_SYNC_ON];         // [R3]
    sync_off_d   = dflt[PIN_SYNC_OFF] && fall[PIN_SYNC_OFF];       // [R3]
    pulse_cnt_d = pulse_cnt_q;
    if (pulse_on)
      pulse_cnt_d = pulse_cnt_q - 1'b1;
    else if (dflt[PIN_CLEAR] && load_on && !load_prev_q && !prot_active)
      pulse_cnt_d = PULSE_W'(PULSE_CYCLES);              // [R11]
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out      <= '1;
      pin_oe       <= '0;
      level_prev_q <= '0;
      pulse_cnt_q  <= '0;
      load_prev_q  <= 1'b0;
      prot_clear   <= 1'b0;
      trigger      <= 1'b0;
      inhibit      <= 1'b0;
      sync_on      <= 1'b0;
      sync_off     <= 1'b0;
    end else begin
      pin_out      <= pin_out_d;
      pin_oe       <= pin_oe_d;
      level_prev_q <= level;
      pulse_cnt_q  <= pulse_cnt_d;
      load_prev_q  <= load_on;
      prot_clear   <= prot_clear_d;
      trigger      <= trigger_d;
      inhibit      <= inhibit_d;
      sync_on      <= sync_on_d;
      sync_off     <= sync_off_d;
    end
  end
  // APB read path: data latched in setup, so access never waits
  logic [DATA_W-1:0] rdata_d;
  logic              err_d;
  always_comb begin
    rdata_d = '0;
    err_d   = 1'b1;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (paddr == slot(CFG_BASE, i)) begin
        rdata_d = DATA_W'(cfg_q[i]);
        err_d   = 1'b0;
      end
      if (paddr == slot(PERIOD_BASE, i)) begin
        rdata_d = DATA_W'(period_q[i]);
        err_d   = 1'b0;
      end
      if (paddr == slot(LOW_BASE, i)) begin
        rdata_d = DATA_W'(low_q[i]);
        err_d   = 1'b0;
      end
    end
    if (paddr == CTRL_ADDR) begin
      rdata_d[CTRL_EXT_TRIG_BIT] = ext_trig_q;
      err_d                      = 1'b0;
    end
    if (paddr == STATUS_ADDR) begin
      rdata_d[NUM_PINS-1:0]    = pin_true;               // [R6]
      rdata_d[STATUS_PROT_BIT] = prot_active;
      rdata_d[STATUS_LOAD_BIT] = load_on;
      err_d                    = 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        prdata  <= pwrite ? '0 : rdata_d;
        pslverr <= err_d;
      end
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_clear_start;
    dflt[PIN_CLEAR] && $rose(pulse_on);
  endsequence
  sequence s_clear_drive;
    (pin_oe[PIN_CLEAR] && pin_out[PIN_CLEAR] == cfg_q[PIN_CLEAR].invert)[*8];
  endsequence

  a_out_level: // [R5] [R8]
    assert property (cfg_q[2].mode == MODE_OUTPUT |=> pin_oe[2] &&
                     pin_out[2] == ($past(cfg_q[2].value) ~^
                                    $past(cfg_q[2].invert)))
    else $error("generic output level wrong");
  a_input_released: // [R6]
    assert property (cfg_q[6].mode == MODE_INPUT |=> !pin_oe[6])
    else $error("input pin is driven");
  a_pwm_drive: // [R7] [R13]
    assert property (cfg_q[1].mode == MODE_PWM |=> pin_oe[1] &&
                     pin_out[1] == ($past(pwm_low[1]) ~^
                                    $past(cfg_q[1].invert)))
    else $error("pwm pin level wrong");
  a_prot_level: // [R2]
    assert property (dflt[PIN_PROT] |=> pin_oe[PIN_PROT] &&
                     pin_out[PIN_PROT] == (!$past(prot_active) ^
                                           $past(cfg_q[PIN_PROT].invert)))
    else $error("protection indicator wrong");
  a_clear_in: // [R10]
    assert property (prot_clear_d |=> prot_clear)
    else $error("protection clear missed");
  a_clear_cause: // [R10] [R4]
    assert property (prot_clear |-> $past(fall[PIN_CLEAR]) &&
                     $past(prot_active))
    else $error("spurious protection clear");
  a_clear_out: // [R11]
    assert property (s_clear_start |=> s_clear_drive)
    else $error("clear pulse too short");
  a_trig_ext: // [R12]
    assert property (trigger |-> $past(ext_trig_q) &&
                     $past(fall[PIN_TRIG]) && $past(dflt[PIN_TRIG]))
    else $error("trigger without external edge");
  a_sync_edge: // [R3] [R4]
    assert property (dflt[PIN_SYNC_ON] && fall[PIN_SYNC_ON] |=> sync_on)
    else $error("sync on edge missed");
  a_inhibit_level: // [R9]
    assert property (dflt[PIN_INHIBIT] |=>
                     inhibit == $past(level[PIN_INHIBIT]))
    else $error("inhibit does not follow pin");
endmodule

// *** verif/dio_far_end.sv ***
// Far-end equipment wired to the seven-pin connector.
// Assumes a pull-up on every line; the port wins any contention.
`timescale 1ns/10ps
module dio_far_end
  import dio_pkg::*;
(
  input  wire logic [dio_pkg::NUM_PINS-1:0] pin_out,
  input  wire logic [dio_pkg::NUM_PINS-1:0] pin_oe,
  input  wire logic [dio_pkg::NUM_PINS-1:0] drv_en,
  input  wire logic [dio_pkg::NUM_PINS-1:0] drv_lvl,
  output logic      [dio_pkg::NUM_PINS-1:0] pin_in
);
  // A released line goes to the pull-up, so a release is a rising edge
  // and never counts as a pulse
  always_comb begin
    for (int k = 0; k < NUM_PINS; k++) begin
      if (pin_oe[k]) pin_in[k] = pin_out[k];
      else if (drv_en[k]) pin_in[k] = drv_lvl[k];
      else pin_in[k] = 1'b1;
    end
  end
endmodule

// *** verif/test_digital_io_port.sv ***
// Self-checking bench of the seven-pin digital I/O port.
// Assumes the far-end model closes the pin loop; APB as master.
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module test_digital_io_port;
  import dio_pkg::*;
  logic        pclk = 0, presetn = 0;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, er;
  logic [6:0]  pin_in, pin_out, pin_oe, drv_en = '0, drv_lvl = '1;
  logic        prot_active = 0, load_on = 0;
  logic        prot_clear, trigger, inhibit, sync_on, sync_off;
  logic [7:0]  n_clr = 0, n_trg = 0, n_on = 0, n_off = 0;
  int          n_errors = 0, num_checks = 0, n;

  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    n_clr <= n_clr + prot_clear;
    n_trg <= n_trg + trigger;
    n_on  <= n_on + sync_on;
    n_off <= n_off + sync_off;
  end

  digital_io_port digital_io_port_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .prot_active(prot_active), .load_on(load_on), .prot_clear(prot_clear),
    .trigger(trigger), .inhibit(inhibit), .sync_on(sync_on),
    .sync_off(sync_off));
  dio_far_end dio_far_end_inst (.pin_out(pin_out), .pin_oe(pin_oe),
    .drv_en(drv_en), .drv_lvl(drv_lvl), .pin_in(pin_in));

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge pclk);
    #1;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_errors++;
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pin(input int k, input logic en, input logic lv);
    @(posedge pclk);
    drv_en[k] <= en;
    drv_lvl[k] <= lv;
  endtask

  // High-to-low pulse, then release back to the pull-up
  task automatic pulse(input int k);
    pin(k, 1'b1, 1'b1);
    settle(2);
    pin(k, 1'b1, 1'b0);
    settle(4);
    pin(k, 1'b0, 1'b1);
    settle(3);
  endtask

  task automatic t_reset();
    repeat (10) @(posedge pclk);
    `CHK(pin_out, 7'h7f)
    `CHK(pin_oe, 7'h00)
    presetn <= 1'b1;
    apb(1'b0, CFG_BASE + 8'h18, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 8'h70, 32'h0);
    `CHK(er, 1'b1)
    $display("test reset done");
  endtask

  task automatic t_events();
    prot_active <= 1'b1;
    pulse(3);
    `CHK(n_trg, 8'h0)
    apb(1'b1, CTRL_ADDR, 32'h1);
    pulse(0);
    `CHK(n_clr, 8'h1)
    pulse(3);
    `CHK(n_trg, 8'h1)
    pulse(5);
    `CHK(n_on, 8'h1)
    pulse(6);
    `CHK(n_off, 8'h1)
    $display("test events done");
  endtask

  task automatic t_inhibit();
    pin(4, 1'b1, 1'b1);
    settle(3);
    `CHK(inhibit, 1'b1)
    pin(4, 1'b1, 1'b0);
    settle(3);
    `CHK(inhibit, 1'b0)
    apb(1'b1, CFG_BASE + 8'h10, 32'h8);
    settle(3);
    `CHK(inhibit, 1'b1)
    pin(4, 1'b0, 1'b1);
    settle(3);
    `CHK(inhibit, 1'b0)
    apb(1'b1, CFG_BASE + 8'h10, 32'h0);
    $display("test inhibit done");
  endtask

  task automatic t_status_pins();
    settle(2);
    `CHK(pin_oe[1], 1'b1)
    `CHK(pin_out[1], 1'b0)
    `CHK(pin_out[2], 1'b0)
    @(posedge pclk);
    prot_active <= 1'b0;
    settle(3);
    `CHK(pin_out[1], 1'b1)
    $display("test status pins done");
  endtask

  task automatic t_generic();
    apb(1'b1, CFG_BASE + 8'h08, 32'h6);
    settle(3);
    `CHK({pin_oe[2], pin_out[2]}, 2'b10)
    apb(1'b1, CFG_BASE + 8'h08, 32'h2);
    settle(3);
    `CHK(pin_out[2], 1'b1)
    apb(1'b1, CFG_BASE + 8'h08, 32'he);
    settle(3);
    `CHK(pin_out[2], 1'b1)
    apb(1'b1, CFG_BASE + 8'h18, 32'h1);
    pin(6, 1'b1, 1'b0);
    settle(3);
    `CHK(pin_oe[6], 1'b0)
    apb(1'b0, STATUS_ADDR, 32'h0);
    `CHK(rd[6], 1'b1)
    pin(6, 1'b0, 1'b1);
    settle(3);
    apb(1'b0, STATUS_ADDR, 32'h0);
    `CHK(rd[6], 1'b0)
    $display("test generic done");
  endtask

  task automatic t_pwm();
    int lows;
    lows = 0;
    apb(1'b1, PERIOD_BASE + 8'h04, 32'h4);
    apb(1'b1, LOW_BASE + 8'h04, 32'h1);
    apb(1'b1, CFG_BASE + 8'h04, 32'h3);
    settle(4);
    `CHK(pin_oe[1], 1'b1)
    // Forty cycles hold whole periods, so any phase gives one count
    for (int c = 0; c < 40; c++) begin
      settle(1);
      if (pin_out[1] === 1'b0) lows++;
    end
    `CHK(lows, 10)
    $display("test pwm done");
  endtask

  task automatic t_clear_out();
    @(posedge pclk);
    load_on <= 1'b1;
    for (n = 0; n < 5 && pin_oe[0] !== 1'b1; n++) settle(1);
    `CHK(pin_out[0], 1'b0)
    for (n = 0; n < 3000 && pin_oe[0] === 1'b1; n++) settle(1);
    `CHK(n, PULSE_CYCLES)
    `CHK(n_clr, 8'h1)
    $display("test clear out done");
  endtask

  initial begin
    #1000000;
    n_errors++;
    print_verdict();
  end

  initial begin
    t_reset();
    t_events();
    t_inhibit();
    t_status_pins();
    t_generic();
    t_pwm();
    t_clear_out();
    print_verdict();
  end
endmodule
